// ==== hdl/fcc_decim_counter.sv ====
// one decimating stage counter: one output strobe per (rate_m1 + 1) inputs
// assumes in_valid is a one-cycle strobe in the sys_clk domain
`timescale 1ns/1ps
module fcc_decim_counter (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       in_valid,
  input  wire logic [7:0] rate_m1,
  output logic            out_strobe
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic       at_end;

  // compare with >= so a rate lowered mid-count still reloads
  assign at_end     = (count >= rate_m1);
  assign out_strobe = in_valid & at_end & ~clear;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = 8'h00;
    end else if (in_valid) begin
      next_count = at_end ? 8'h00 : count + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ==== hdl/fcc_filter_chain_cfg.sv ====
// filter chain configuration registers, soft-reset control, decimation strobes,
// FIR coefficient address sequencing and 16-bit output scaling
// assumes a host on the internal 10-bit register port and a FIR datapath outside
`timescale 1ns/1ps
module fcc_filter_chain_cfg (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [9:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic               sample_valid,
  output logic                    sample_accept,
  output logic                    comb2_strobe,
  output logic                    comb5_strobe,
  output logic                    fir_strobe,
  output logic                    accum_clear,
  output fcc_pkg::fcc_cfg_t       cfg,
  output fcc_pkg::fcc_coeff_t     coeff,
  input  wire logic [22:0]        fir_result_23b,
  input  wire logic               fir_result_valid,
  input  wire fcc_pkg::fcc_wl_t   serial_word_length,
  output logic      [15:0]        output_word_16b,
  output logic                    output_valid,
  output logic                    output_port_en,
  output logic                    sync_oe
);

  // register group
  logic [7:0] mode_reg;
  logic [7:0] comb2_decim;
  logic [4:0] comb5_scale;
  logic [7:0] comb5_decim;
  logic [3:0] out_fir_ctrl;
  logic [7:0] fir_decim;
  logic [7:0] fir_coeff_off;
  logic [7:0] fir_tap_count;
  logic [7:0] reserved_cfg;
  logic [7:0] next_mode_reg;
  logic [7:0] next_comb2_decim;
  logic [4:0] next_comb5_scale;
  logic [7:0] next_comb5_decim;
  logic [3:0] next_out_fir_ctrl;
  logic [7:0] next_fir_decim;
  logic [7:0] next_fir_coeff_off;
  logic [7:0] next_fir_tap_count;
  logic [7:0] next_reserved_cfg;
  logic [7:0] next_reg_rdata;

  always_comb begin
    next_mode_reg      = mode_reg;
    next_comb2_decim   = comb2_decim;
    next_comb5_scale   = comb5_scale;
    next_comb5_decim   = comb5_decim;
    next_out_fir_ctrl  = out_fir_ctrl;
    next_fir_decim     = fir_decim;
    next_fir_coeff_off = fir_coeff_off;
    next_fir_tap_count = fir_tap_count;
    next_reserved_cfg  = reserved_cfg;
    if (reg_wr) begin
      case (reg_addr)
        fcc_pkg::ADDR_MODE:          next_mode_reg      = {4'h0, reg_wdata[3:0]};
        fcc_pkg::ADDR_COMB2_DECIM:   next_comb2_decim   = reg_wdata;
        fcc_pkg::ADDR_COMB5_SCALE:   next_comb5_scale   = reg_wdata[4:0];
        fcc_pkg::ADDR_COMB5_DECIM:   next_comb5_decim   = reg_wdata;
        fcc_pkg::ADDR_OUT_FIR_CTRL:  next_out_fir_ctrl  = reg_wdata[3:0];
        fcc_pkg::ADDR_FIR_DECIM:     next_fir_decim     = reg_wdata;
        fcc_pkg::ADDR_FIR_COEFF_OFF: next_fir_coeff_off = reg_wdata;
        fcc_pkg::ADDR_FIR_TAP_COUNT: next_fir_tap_count = reg_wdata;
        fcc_pkg::ADDR_RESERVED_CFG:  next_reserved_cfg  = reg_wdata;
        default:                     next_mode_reg      = mode_reg;
      endcase
    end
    // read data registered; unmapped addresses read zero
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        fcc_pkg::ADDR_MODE:          next_reg_rdata = mode_reg;
        fcc_pkg::ADDR_COMB2_DECIM:   next_reg_rdata = comb2_decim;
        fcc_pkg::ADDR_COMB5_SCALE:   next_reg_rdata = {3'h0, comb5_scale};
        fcc_pkg::ADDR_COMB5_DECIM:   next_reg_rdata = comb5_decim;
        fcc_pkg::ADDR_OUT_FIR_CTRL:  next_reg_rdata = {4'h0, out_fir_ctrl};
        fcc_pkg::ADDR_FIR_DECIM:     next_reg_rdata = fir_decim;
        fcc_pkg::ADDR_FIR_COEFF_OFF: next_reg_rdata = fir_coeff_off;
        fcc_pkg::ADDR_FIR_TAP_COUNT: next_reg_rdata = fir_tap_count;
        fcc_pkg::ADDR_RESERVED_CFG:  next_reg_rdata = reserved_cfg;
        default:                     next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_reg      <= fcc_pkg::MODE_RESET;
      comb2_decim   <= fcc_pkg::CFG_RESET;
      comb5_scale   <= 5'h00;
      comb5_decim   <= fcc_pkg::CFG_RESET;
      out_fir_ctrl  <= 4'h0;
      fir_decim     <= fcc_pkg::CFG_RESET;
      fir_coeff_off <= fcc_pkg::CFG_RESET;
      fir_tap_count <= fcc_pkg::CFG_RESET;
      reserved_cfg  <= fcc_pkg::CFG_RESET;
      reg_rdata     <= 8'h00;
    end else begin
      mode_reg      <= next_mode_reg;
      comb2_decim   <= next_comb2_decim;
      comb5_scale   <= next_comb5_scale;
      comb5_decim   <= next_comb5_decim;
      out_fir_ctrl  <= next_out_fir_ctrl;
      fir_decim     <= next_fir_decim;
      fir_coeff_off <= next_fir_coeff_off;
      fir_tap_count <= next_fir_tap_count;
      reserved_cfg  <= next_reserved_cfg;
      reg_rdata     <= next_reg_rdata;
    end
  end

  // decoded configuration
  logic soft_reset;
  logic running;

  assign soft_reset = mode_reg[fcc_pkg::MODE_SOFT_BIT];
  assign running    = ~soft_reset;

  always_comb begin
    cfg                     = '0;
    cfg.soft_reset          = soft_reset;
    cfg.sync_master         = running & mode_reg[fcc_pkg::MODE_SYNC_BIT];
    // complex wins over diversity if both bits are set
    if (mode_reg[fcc_pkg::MODE_CPLX_BIT]) begin
      cfg.chan_mode = fcc_pkg::FCC_CH_COMPLEX;
    end else if (mode_reg[fcc_pkg::MODE_DIV_BIT]) begin
      cfg.chan_mode = fcc_pkg::FCC_CH_DIVERSITY;
    end else begin
      cfg.chan_mode = fcc_pkg::FCC_CH_SINGLE_REAL;
    end
    cfg.comb2_decim_rate_m1 = comb2_decim;
    cfg.comb5_scale_factor  = comb5_scale;
    cfg.comb5_decim_rate_m1 = comb5_decim;
    cfg.out_scale           = out_fir_ctrl[fcc_pkg::OUT_SCALE_HI:0];
    cfg.unique_b            = out_fir_ctrl[fcc_pkg::UNIQUE_B_BIT];
    cfg.fir_decim_rate_m1   = fir_decim;
    cfg.fir_coeff_base      = fir_coeff_off;
    cfg.fir_tap_count_m1    = fir_tap_count;
  end

  // soft reset gates input, processing, output ports and sync drive
  assign sample_accept  = running;
  assign output_port_en = running;
  assign sync_oe        = cfg.sync_master;

  // pin_reset_state clear pulse; FIR data memory is deliberately not touched
  logic next_accum_clear;

  always_comb begin
    next_accum_clear = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      accum_clear <= 1'b1;
    end else begin
      accum_clear <= next_accum_clear;
    end
  end

  // decimation chain, cleared while held in soft reset
  logic stage_clear;

  assign stage_clear = soft_reset | accum_clear;

  fcc_decim_counter u_comb2_decim (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clear      (stage_clear),
    .in_valid   (sample_valid & running),
    .rate_m1    (comb2_decim),
    .out_strobe (comb2_strobe)
  );

  fcc_decim_counter u_comb5_decim (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clear      (stage_clear),
    .in_valid   (comb2_strobe),
    .rate_m1    (comb5_decim),
    .out_strobe (comb5_strobe)
  );

  fcc_decim_counter u_fir_decim (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clear      (stage_clear),
    .in_valid   (comb5_strobe),
    .rate_m1    (fir_decim),
    .out_strobe (fir_strobe)
  );

  // coefficient sequencer: one pass per channel over taps 0..tap count, addressed from base, stride 2 when unique_b is set
  fcc_pkg::fcc_seq_t seq_state;
  fcc_pkg::fcc_seq_t next_seq_state;
  logic [7:0]        tap_idx;
  logic [7:0]        next_tap_idx;
  logic              tap_last;
  logic              second_pass;

  assign tap_last    = (tap_idx == fir_tap_count);
  assign second_pass = (cfg.chan_mode != fcc_pkg::FCC_CH_SINGLE_REAL);

  always_comb begin
    next_seq_state = seq_state;
    next_tap_idx   = tap_idx;
    case (seq_state)
      fcc_pkg::FCC_SEQ_IDLE: begin
        next_tap_idx = 8'h00;
        if (fir_strobe) begin
          next_seq_state = fcc_pkg::FCC_SEQ_CHAN_A;
        end
      end
      fcc_pkg::FCC_SEQ_CHAN_A: begin
        next_tap_idx = tap_idx + 8'h01;
        if (tap_last) begin
          next_tap_idx   = 8'h00;
          next_seq_state = second_pass ? fcc_pkg::FCC_SEQ_CHAN_B : fcc_pkg::FCC_SEQ_IDLE;
        end
      end
      fcc_pkg::FCC_SEQ_CHAN_B: begin
        next_tap_idx = tap_idx + 8'h01;
        if (tap_last) begin
          next_tap_idx   = 8'h00;
          next_seq_state = fcc_pkg::FCC_SEQ_IDLE;
        end
      end
      default: begin
        next_tap_idx   = 8'h00;
        next_seq_state = fcc_pkg::FCC_SEQ_IDLE;
      end
    endcase
    if (soft_reset) begin
      next_tap_idx   = 8'h00;
      next_seq_state = fcc_pkg::FCC_SEQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seq_state <= fcc_pkg::FCC_SEQ_IDLE;
      tap_idx   <= 8'h00;
    end else begin
      seq_state <= next_seq_state;
      tap_idx   <= next_tap_idx;
    end
  end

  // coefficient address: wraps at 256, no symmetry folding
  logic       chan_b;
  logic [7:0] coeff_addr;

  assign chan_b = (seq_state == fcc_pkg::FCC_SEQ_CHAN_B);

  always_comb begin
    if (cfg.unique_b) begin
      coeff_addr = fir_coeff_off + {tap_idx[6:0], chan_b};
    end else begin
      coeff_addr = fir_coeff_off + tap_idx;
    end
  end

  always_comb begin
    coeff        = '0;
    coeff.valid  = (seq_state != fcc_pkg::FCC_SEQ_IDLE);
    coeff.chan_b = chan_b;
    coeff.last   = tap_last & (seq_state != fcc_pkg::FCC_SEQ_IDLE);
    coeff.addr   = coeff_addr;
  end

  // output scaling and rounding to 16 bits with saturation
  logic [2:0]          eff_scale;
  logic signed [31:0]  fir_ext;
  logic signed [31:0]  fir_scaled;
  logic signed [31:0]  fir_round;
  logic [15:0]         scaled_word;

  always_comb begin
    // wide serial words bypass the scale field and use unity
    if (serial_word_length == fcc_pkg::FCC_WL_16) begin
      eff_scale = cfg.out_scale;
    end else begin
      eff_scale = fcc_pkg::OUT_SCALE_UNITY;
    end
    fir_ext    = {{(fcc_pkg::SCALE_W - fcc_pkg::FIR_W){fir_result_23b[22]}}, fir_result_23b};
    fir_scaled = (fir_ext <<< 4) >>> eff_scale;
    fir_round  = (fir_scaled + 32'sh0000_0040) >>> fcc_pkg::DROP_BITS;
    if (fir_round > 32'sh0000_7fff) begin
      scaled_word = 16'h7fff;
    end else if (fir_round < -32'sh0000_8000) begin
      scaled_word = 16'h8000;
    end else begin
      scaled_word = fir_round[15:0];
    end
  end

  // first word after leaving soft reset is forced to zero
  logic        first_out;
  logic        next_first_out;
  logic [15:0] next_output_word;
  logic        next_output_valid;

  always_comb begin
    next_first_out    = first_out;
    next_output_word  = output_word_16b;
    next_output_valid = 1'b0;
    if (soft_reset) begin
      next_first_out   = 1'b1;
      next_output_word = 16'h0000;
    end else if (fir_result_valid) begin
      next_output_valid = 1'b1;
      next_first_out    = 1'b0;
      next_output_word  = first_out ? 16'h0000 : scaled_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      first_out       <= 1'b1;
      output_word_16b <= 16'h0000;
      output_valid    <= 1'b0;
    end else begin
      first_out       <= next_first_out;
      output_word_16b <= next_output_word;
      output_valid    <= next_output_valid;
    end
  end

endmodule

// ==== hdl/fcc_pkg.sv ====
// constants, field positions and carrier types for the filter chain config block
// assumes a single 50 MHz sys_clk domain and a synchronous active-low reset
package fcc_pkg;

  // internal register addresses on the 10-bit control port
  localparam logic [9:0] ADDR_MODE          = 10'h300;
  localparam logic [9:0] ADDR_COMB2_DECIM   = 10'h306;
  localparam logic [9:0] ADDR_COMB5_SCALE   = 10'h307;
  localparam logic [9:0] ADDR_COMB5_DECIM   = 10'h308;
  localparam logic [9:0] ADDR_OUT_FIR_CTRL  = 10'h309;
  localparam logic [9:0] ADDR_FIR_DECIM     = 10'h30a;
  localparam logic [9:0] ADDR_FIR_COEFF_OFF = 10'h30b;
  localparam logic [9:0] ADDR_FIR_TAP_COUNT = 10'h30c;
  localparam logic [9:0] ADDR_RESERVED_CFG  = 10'h30d;

  // field positions
  localparam int MODE_SOFT_BIT    = 0;
  localparam int MODE_DIV_BIT     = 1;
  localparam int MODE_CPLX_BIT    = 2;
  localparam int MODE_SYNC_BIT    = 3;
  localparam int OUT_SCALE_HI     = 2;
  localparam int UNIQUE_B_BIT     = 3;
  localparam int COMB5_SCALE_HI   = 4;

  // values after reset
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  // output scaling: result = fir * 2^(4 - scale), keep 16 of 23 bits
  localparam logic [2:0] OUT_SCALE_UNITY = 3'h4;
  localparam int         FIR_W           = 23;
  localparam int         OUT_W           = 16;
  localparam int         SCALE_W         = 32;
  localparam int         DROP_BITS       = FIR_W - OUT_W;

  // minimum pin_reset_state pulse held by the host
  localparam int CLK_PERIOD_NS      = 20;
  localparam int RESET_MIN_NS       = 30;
  localparam int RESET_MIN_CYCLES   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FCC_WL_16 = 2'b00,
    FCC_WL_24 = 2'b01,
    FCC_WL_32 = 2'b10
  } fcc_wl_t;

  typedef enum logic [1:0] {
    FCC_CH_SINGLE_REAL = 2'b00,
    FCC_CH_DIVERSITY   = 2'b01,
    FCC_CH_COMPLEX     = 2'b10
  } fcc_chan_mode_t;

  typedef enum logic [2:0] {
    FCC_SEQ_IDLE   = 3'b001,
    FCC_SEQ_CHAN_A = 3'b010,
    FCC_SEQ_CHAN_B = 3'b100
  } fcc_seq_t;

  typedef struct packed {
    logic           soft_reset;
    logic           sync_master;
    fcc_chan_mode_t chan_mode;
    logic [7:0]     comb2_decim_rate_m1;
    logic [4:0]     comb5_scale_factor;
    logic [7:0]     comb5_decim_rate_m1;
    logic [2:0]     out_scale;
    logic           unique_b;
    logic [7:0]     fir_decim_rate_m1;
    logic [7:0]     fir_coeff_base;
    logic [7:0]     fir_tap_count_m1;
  } fcc_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       chan_b;
    logic       last;
    logic [7:0] addr;
  } fcc_coeff_t;

endpackage

// ==== verif/fcc_filter_chain_cfg_monitor.sv ====
// checker for the filter chain config block, bound to its top module
// assumes one sys_clk domain and a synchronous active-low rst_n
`timescale 1ns/1ps
module fcc_filter_chain_cfg_monitor (
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [9:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic                sample_valid,
  input wire logic                sample_accept,
  input wire logic                comb2_strobe,
  input wire logic                fir_strobe,
  input wire logic                accum_clear,
  input wire fcc_pkg::fcc_cfg_t   cfg,
  input wire fcc_pkg::fcc_coeff_t coeff,
  input wire logic                fir_result_valid,
  input wire logic                output_valid,
  input wire logic                output_port_en,
  input wire logic                sync_oe
);
  logic [7:0] cnt2;
  logic [7:0] next_cnt2;

  // own count of accepted samples; assumes rates change only in soft reset
  always_comb begin
    next_cnt2 = cnt2;
    if (accum_clear || cfg.soft_reset) next_cnt2 = 8'h00;
    else if (sample_valid && sample_accept)
      next_cnt2 = (cnt2 == cfg.comb2_decim_rate_m1) ? 8'h00 : cnt2 + 8'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) cnt2 <= 8'h00;
    else cnt2 <= next_cnt2;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_release_soft: assert property ($rose(rst_n) |-> accum_clear && !sample_accept
    && !output_port_en && !sync_oe) else $error("bad state on reset release");
  a_soft_idle: assert property (cfg.soft_reset && $past(cfg.soft_reset) |->
    !sample_accept && !output_port_en && !sync_oe && !comb2_strobe && !output_valid)
    else $error("activity during soft reset");
  a_run_active: assert property (!cfg.soft_reset |-> sample_accept && output_port_en)
    else $error("not running with soft reset clear");
  a_mode_write: assert property (reg_wr && reg_addr == fcc_pkg::ADDR_MODE |=>
    cfg.soft_reset == $past(reg_wdata[0])
    && sync_oe == ($past(reg_wdata[3]) && !$past(reg_wdata[0])))
    else $error("mode write not applied");
  a_scale_read: assert property (reg_rd && !reg_wr && reg_addr == fcc_pkg::ADDR_COMB5_SCALE
    |=> reg_rdata == {3'h0, cfg.comb5_scale_factor}) else $error("scale readback wrong");
  a_comb2_rate: assert property (sample_valid && sample_accept |->
    comb2_strobe == (cnt2 == cfg.comb2_decim_rate_m1)) else $error("stage two rate wrong");
  a_strobe_cause: assert property (comb2_strobe |-> sample_valid && sample_accept)
    else $error("stage two strobe without sample");
  a_coeff_start: assert property (fir_strobe && !coeff.valid && !cfg.soft_reset |=>
    coeff.valid && !coeff.chan_b && coeff.addr == cfg.fir_coeff_base)
    else $error("tap walk did not start at base");
  a_coeff_step: assert property (coeff.valid && !coeff.last && !cfg.soft_reset |=>
    coeff.valid && coeff.chan_b == $past(coeff.chan_b)
    && coeff.addr == $past(coeff.addr) + (cfg.unique_b ? 8'h02 : 8'h01))
    else $error("tap address step wrong");
  a_out_latency: assert property (fir_result_valid && output_port_en |=> output_valid)
    else $error("output word missing");
  a_out_gate: assert property (fir_result_valid && !output_port_en |=> !output_valid)
    else $error("output while inactive");
endmodule

bind fcc_filter_chain_cfg fcc_filter_chain_cfg_monitor u_mon (.sys_clk(sys_clk),
  .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .sample_accept(sample_accept), .comb2_strobe(comb2_strobe), .fir_strobe(fir_strobe),
  .accum_clear(accum_clear), .cfg(cfg), .coeff(coeff), .fir_result_valid(fir_result_valid),
  .output_valid(output_valid), .output_port_en(output_port_en), .sync_oe(sync_oe));

// ==== verif/fcc_filter_chain_cfg_tb.sv ====
// self-checking bench for the filter chain config block
// assumes the host model drives the register port and the reset pin
`timescale 1ns/1ps
module fcc_filter_chain_cfg_tb;
  logic                rst_n, reg_wr, reg_rd, sample_valid, sample_accept, sys_clk;
  logic                comb2_strobe, comb5_strobe, fir_strobe, accum_clear;
  logic                fir_result_valid, output_valid, output_port_en, sync_oe;
  logic [9:0]          reg_addr;
  logic [7:0]          reg_wdata, reg_rdata, d;
  logic [22:0]         fir_result_23b;
  logic [15:0]         output_word_16b;
  fcc_pkg::fcc_cfg_t   cfg;
  fcc_pkg::fcc_coeff_t coeff;
  fcc_pkg::fcc_wl_t    serial_word_length;
  int                  err_count, total_checks, n_c2, n_c5, n_fir, n_last;
  logic [8:0]          taps_q[$];

  fcc_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  fcc_filter_chain_cfg DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_accept(sample_accept), .comb2_strobe(comb2_strobe),
    .comb5_strobe(comb5_strobe), .fir_strobe(fir_strobe), .accum_clear(accum_clear),
    .cfg(cfg), .coeff(coeff), .fir_result_23b(fir_result_23b),
    .fir_result_valid(fir_result_valid), .serial_word_length(serial_word_length),
    .output_word_16b(output_word_16b), .output_valid(output_valid),
    .output_port_en(output_port_en), .sync_oe(sync_oe));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (comb2_strobe === 1'b1) n_c2++;
    if (comb5_strobe === 1'b1) n_c5++;
    if (fir_strobe === 1'b1) n_fir++;
    if (coeff.valid === 1'b1) taps_q.push_back({coeff.chan_b, coeff.addr});
    if ({coeff.valid, coeff.last} === 2'b11) n_last++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // only scales 0..4 are modelled, where the scaled value is whole
  function automatic logic [15:0] scale_exp(input logic [22:0] fir, input int s);
    longint x;
    x = $signed(fir);
    x = ((x <<< (4 - s)) + 64) >>> 7;
    if (x > 32767) x = 32767;
    if (x < -32768) x = -32768;
    return x[15:0];
  endfunction

  task automatic samples(input int n);
    @(posedge sys_clk);
    #1 sample_valid = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1 sample_valid = 1'b0;
  endtask

  task automatic res(input logic [22:0] fir, input logic on, input logic [15:0] exp);
    @(posedge sys_clk);
    #1;
    fir_result_23b = fir;
    fir_result_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    fir_result_valid = 1'b0;
    fir_result_23b = ~fir;
    chk(output_valid, on);
    if (on) chk(output_word_16b, exp);
  endtask

  task automatic t_reset;
    host.rd(fcc_pkg::ADDR_MODE, d);
    chk(d, fcc_pkg::MODE_RESET);
    chk({sample_accept, output_port_en, sync_oe}, 3'h0);
  endtask

  task automatic t_regs;
    logic [7:0] msk [8];
    msk = '{8'hff, 8'h1f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h00};
    for (int a = 0; a < 8; a++) begin
      host.rd(10'h306 + 10'(a), d);
      chk(d, fcc_pkg::CFG_RESET);
      host.wr(10'h306 + 10'(a), msk[a]);
      host.rd(10'h306 + 10'(a), d);
      chk(d, msk[a]);
    end
    host.wr(10'h301, 8'hff);
    host.rd(10'h301, d);
    chk(d, 8'h00);
  endtask

  task automatic t_decim;
    host.setup(8'h00, 8'h04, 8'h00, 8'h00, 8'h02, 8'h01, 8'h01);
    n_c2 = 0;
    n_c5 = 0;
    n_fir = 0;
    samples(24);
    repeat (6) @(posedge sys_clk);
    chk(n_c2, 8);
    chk(n_c5, 4);
    chk(n_fir, 2);
  endtask

  task automatic t_coeff(input logic [7:0] mode, input logic [7:0] ctrl, input logic [7:0] base,
                         input logic [7:0] taps, input logic [3:0][8:0] exp, input int n);
    host.setup(mode, ctrl, base, taps, 8'h00, 8'h00, 8'h00);
    chk(cfg.chan_mode, mode[2:1]);
    taps_q.delete();
    n_last = 0;
    samples(1);
    repeat (12) @(posedge sys_clk);
    chk(taps_q.size(), n);
    chk(n_last, (mode[2:1] == 2'b00) ? 1 : 2);
    for (int i = 0; i < n; i++) chk(taps_q[i], exp[3-i]);
  endtask

  task automatic t_output;
    host.setup(8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    res(23'h00_0080, 1'b1, 16'h0000);
    res(23'h00_0080, 1'b1, scale_exp(23'h00_0080, 4));
    res(23'h7f_ff00, 1'b1, scale_exp(23'h7f_ff00, 4));
    host.setup(8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    res(23'h00_1234, 1'b1, 16'h0000);
    res(23'h00_1234, 1'b1, scale_exp(23'h00_1234, 2));
    serial_word_length = fcc_pkg::FCC_WL_24;
    host.setup(8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    res(23'h01_2345, 1'b1, 16'h0000);
    res(23'h01_2345, 1'b1, scale_exp(23'h01_2345, 4));
    serial_word_length = fcc_pkg::FCC_WL_32;
    res(23'h00_4567, 1'b1, scale_exp(23'h00_4567, 4));
    serial_word_length = fcc_pkg::FCC_WL_16;
  endtask

  task automatic t_mode;
    host.setup(8'h08, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    chk({sync_oe, cfg.sync_master, output_port_en}, 3'h7);
    host.wr(fcc_pkg::ADDR_MODE, 8'h01);
    chk({sync_oe, sample_accept, output_port_en}, 3'h0);
    n_c2 = 0;
    samples(3);
    res(23'h00_0100, 1'b0, 16'h0000);
    chk(n_c2, 0);
    host.rd(fcc_pkg::ADDR_MODE, d);
    chk(d, 8'h01);
  endtask

  task automatic t_hard;
    host.setup(8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    host.pin_reset_state(2);
    chk({accum_clear, sample_accept}, 2'h2);
    host.rd(fcc_pkg::ADDR_MODE, d);
    chk(d, fcc_pkg::MODE_RESET);
    chk(accum_clear, 1'b0);
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    sample_valid = 1'b0;
    fir_result_valid = 1'b0;
    fir_result_23b = 23'h00_0000;
    serial_word_length = fcc_pkg::FCC_WL_16;
    host.pin_reset_state(12);
    t_reset();
    t_regs();
    t_decim();
    t_coeff(8'h00, 8'h04, 8'hfe, 8'h02, {9'h0fe, 9'h0ff, 9'h000, 9'h000}, 3);
    t_coeff(8'h02, 8'h0c, 8'h04, 8'h01, {9'h004, 9'h006, 9'h105, 9'h107}, 4);
    t_coeff(8'h04, 8'h04, 8'h0a, 8'h00, {9'h00a, 9'h10a, 9'h000, 9'h000}, 2);
    t_output();
    t_mode();
    t_hard();
    wrap_up();
  end

  // the sequence needs well under 2000 cycles
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule

// ==== verif/fcc_host_model.sv ====
// host model: drives the register strobe port and the reset pin
// assumes sys_clk from the bench; lines change 1 ns after a rising edge
`timescale 1ns/1ps
module fcc_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            rst_n,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [9:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 10'h000;
    reg_wdata = 8'h00;
  end

  // whole cycles only; callers pass at least 2 cycles, 40 ns, above the 30 ns minimum
  task automatic pin_reset_state(input int cycles);
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (cycles) @(posedge sys_clk);
    #1 rst_n = 1'b1;
  endtask

  // only the control port is used, the serial port sleeps in soft reset
  task automatic access(input logic wr, input logic [9:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = wr;
    reg_rd    = !wr;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // released lines show the inverse so a stray capture is visible
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    access(1'b1, addr, data);
  endtask

  task automatic rd(input logic [9:0] addr, output logic [7:0] data);
    access(1'b0, addr, 8'h00);
    data = reg_rdata;
  endtask

  // callers keep resident taps below 256, or 128 per channel
  task automatic setup(input logic [7:0] mode, input logic [7:0] ctrl, input logic [7:0] base,
                       input logic [7:0] taps, input logic [7:0] c2, input logic [7:0] c5,
                       input logic [7:0] fm);
    wr(fcc_pkg::ADDR_MODE, mode | 8'h01);
    wr(fcc_pkg::ADDR_COMB2_DECIM, c2);
    wr(fcc_pkg::ADDR_COMB5_SCALE, 8'h00);
    wr(fcc_pkg::ADDR_COMB5_DECIM, c5);
    wr(fcc_pkg::ADDR_OUT_FIR_CTRL, ctrl & 8'h0f);
    wr(fcc_pkg::ADDR_FIR_DECIM, fm);
    wr(fcc_pkg::ADDR_FIR_COEFF_OFF, base);
    wr(fcc_pkg::ADDR_FIR_TAP_COUNT, taps);
    wr(fcc_pkg::ADDR_RESERVED_CFG, 8'h00);
    wr(fcc_pkg::ADDR_MODE, mode & 8'hfe);
  endtask
endmodule
